// ==== verilog/gpio_dir_polarity_config.sv ====
// Top: APB-reached indexed GPIO direction/polarity bank with power event output
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
module gpio_dir_polarity_config import gpio_cfg_pkg::*; (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [11:0]        paddr_i,
  input  wire logic [31:0]        pwdata_i,
  input  wire logic [3:0]         pstrb_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire logic [N_G1_LO-1:0] group1_low_pins_i,
  output logic      [N_G1_LO-1:0] group1_low_pins_o,
  output logic      [N_G1_LO-1:0] group1_low_pins_oe_o,
  input  wire logic [N_G1_HI-1:0] group1_high_pins_i,
  output logic      [N_G1_HI-1:0] group1_high_pins_o,
  output logic      [N_G1_HI-1:0] group1_high_pins_oe_o,
  input  wire logic [N_G2-1:0]    group2_pins_i,
  output logic      [N_G2-1:0]    group2_pins_o,
  output logic      [N_G2-1:0]    group2_pins_oe_o,
  input  wire logic [N_G3-1:0]    group3_pins_i,
  output logic      [N_G3-1:0]    group3_pins_o,
  output logic      [N_G3-1:0]    group3_pins_oe_o,
  input  wire logic               power_event_i,
  output logic                    power_event_out_n_o,
  output logic                    power_event_oe_o
);

  // ---------------------------------------------------------------------------
  // Reset
  // ---------------------------------------------------------------------------
  logic rst_n;

  reset_sync u_reset_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .rst_n_o   (rst_n)
  );

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [7:0]        ctrl_q,     ctrl_d;
  logic [7:0]        index_q,    index_d;
  logic [7:0]        g1_pol_q,   g1_pol_d;
  logic [7:0]        g2_dir_q,   g2_dir_d;
  logic [7:0]        g2_pol_q,   g2_pol_d;
  logic [7:0]        g3_dir_q,   g3_dir_d;
  logic [7:0]        g1_otype_q, g1_otype_d;
  logic [N_PINS-1:0] pin_out_q,  pin_out_d;
  logic [31:0]       prdata_q,   prdata_d;
  logic              pready_q,   pready_d;
  logic              pslverr_q,  pslverr_d;
  logic              evt_q,      evt_d;
  logic              evt_oe_q,   evt_oe_d;

  logic              cfg_state;
  logic              first_access;
  logic              completing;
  logic              addr_hit;
  logic              idx_hit;
  logic              data_sel;
  logic              access_err;
  logic [7:0]        idx_rdata;
  logic [31:0]       bus_rdata;
  logic [7:0]        wbyte;
  logic [N_PINS-1:0] pin_in_val;
  logic              evt_level;

  assign cfg_state = ctrl_q[CTRL_CFG_STATE_BIT];

  // ---------------------------------------------------------------------------
  // Lane merge for multi-byte registers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ---------------------------------------------------------------------------
  // Indexed read decode
  // ---------------------------------------------------------------------------
  // Masks keep reserved bits at zero even if a stray value were stored
  always_comb begin
    idx_hit   = 1'b1;
    idx_rdata = 8'h00;
    case (index_q)
      IDX_G1_POL:   idx_rdata = g1_pol_q   & MASK_G1_POL;
      IDX_G2_DIR:   idx_rdata = g2_dir_q   & MASK_G2_DIR;
      IDX_G2_POL:   idx_rdata = g2_pol_q   & MASK_G2_POL;
      IDX_G3_DIR:   idx_rdata = g3_dir_q   & MASK_G3_DIR;
      IDX_G1_OTYPE: idx_rdata = g1_otype_q & MASK_G1_OTYPE;
      default:      idx_hit   = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Bus address decode and read mux
  // ---------------------------------------------------------------------------
  // Data window is refused outside config state or on an unknown index
  always_comb begin
    addr_hit  = 1'b1;
    data_sel  = 1'b0;
    bus_rdata = 32'h0000_0000;
    case (paddr_i)
      ADDR_CTRL:    bus_rdata = {24'h00_0000, ctrl_q};
      ADDR_INDEX:   bus_rdata = {24'h00_0000, index_q};
      ADDR_DATA: begin
        data_sel = 1'b1;
        if (cfg_state && idx_hit) begin
          bus_rdata = {24'h00_0000, idx_rdata};
        end
      end
      ADDR_PIN_IN:  bus_rdata = {{(32-N_PINS){1'b0}}, pin_in_val};
      ADDR_PIN_OUT: bus_rdata = {{(32-N_PINS){1'b0}}, pin_out_q};
      default:      addr_hit  = 1'b0;
    endcase
    access_err = !addr_hit || (data_sel && !(cfg_state && idx_hit));
  end

  // ---------------------------------------------------------------------------
  // APB handshake
  // ---------------------------------------------------------------------------
  // One wait state buys registered prdata, pready and pslverr
  always_comb begin
    first_access = psel_i && penable_i && !pready_q;
    completing   = psel_i && penable_i && pready_q;
    pready_d     = first_access;
    prdata_d     = prdata_q;
    pslverr_d    = pslverr_q;
    if (first_access) begin
      prdata_d  = (pwrite_i || access_err) ? 32'h0000_0000 : bus_rdata;
      pslverr_d = access_err;
    end else if (completing) begin
      prdata_d  = 32'h0000_0000;
      pslverr_d = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------------
  // Writes land only at the completing edge; refused ones change nothing
  always_comb begin
    ctrl_d     = ctrl_q;
    index_d    = index_q;
    g1_pol_d   = g1_pol_q;
    g2_dir_d   = g2_dir_q;
    g2_pol_d   = g2_pol_q;
    g3_dir_d   = g3_dir_q;
    g1_otype_d = g1_otype_q;
    pin_out_d  = pin_out_q;
    wbyte      = pwdata_i[7:0];
    if (completing && pwrite_i && !access_err) begin
      case (paddr_i)
        ADDR_CTRL: begin
          if (pstrb_i[0]) begin
            ctrl_d = wbyte & CTRL_MASK;
          end
        end
        ADDR_INDEX: begin
          if (pstrb_i[0]) begin
            index_d = wbyte;
          end
        end
        ADDR_DATA: begin
          if (pstrb_i[0]) begin
            case (index_q)
              IDX_G1_POL:   g1_pol_d   = wbyte & MASK_G1_POL;
              IDX_G2_DIR:   g2_dir_d   = wbyte & MASK_G2_DIR;
              IDX_G2_POL:   g2_pol_d   = wbyte & MASK_G2_POL;
              IDX_G3_DIR:   g3_dir_d   = wbyte & MASK_G3_DIR;
              IDX_G1_OTYPE: g1_otype_d = wbyte & MASK_G1_OTYPE;
              default:      g1_pol_d   = g1_pol_q;
            endcase
          end
        end
        ADDR_PIN_OUT: begin
          pin_out_d = N_PINS'(merge_lanes({{(32-N_PINS){1'b0}}, pin_out_q},
                                          pwdata_i, pstrb_i));
        end
        default: begin
          ctrl_d = ctrl_q;
        end
      endcase
    end
  end

  // All bank state clears on the standby supply reset
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q     <= CFG_RESET;
      index_q    <= IDX_RESET;
      g1_pol_q   <= CFG_RESET;
      g2_dir_q   <= CFG_RESET;
      g2_pol_q   <= CFG_RESET;
      g3_dir_q   <= CFG_RESET;
      g1_otype_q <= CFG_RESET;
      pin_out_q  <= PIN_RESET;
      prdata_q   <= 32'h0000_0000;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      index_q    <= index_d;
      g1_pol_q   <= g1_pol_d;
      g2_dir_q   <= g2_dir_d;
      g2_pol_q   <= g2_pol_d;
      g3_dir_q   <= g3_dir_d;
      g1_otype_q <= g1_otype_d;
      pin_out_q  <= pin_out_d;
      prdata_q   <= prdata_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
    end
  end

  assign prdata_o  = prdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;

  // ---------------------------------------------------------------------------
  // Flat pin configuration vectors
  // ---------------------------------------------------------------------------
  logic [N_PINS-1:0] dir_vec;
  logic [N_PINS-1:0] pol_vec;
  logic [N_PINS-1:0] od_vec;
  logic [N_PINS-1:0] pin_in_vec;
  logic [N_PINS-1:0] pin_out_vec;
  logic [N_PINS-1:0] pin_oe_vec;

  // Group one uses bits 1-3 and 6-7; bits 0, 4, 5 map to no pin
  assign dir_vec = {g3_dir_q, g2_dir_q[3:0], 5'b0_0000};  // Group one direction lives elsewhere
  assign pol_vec = {8'h00, g2_pol_q[3:0], g1_pol_q[7:6], g1_pol_q[3:1]};
  assign od_vec  = {12'h000, g1_otype_q[7:6], g1_otype_q[3:1]};
  assign pin_in_vec = {group3_pins_i, group2_pins_i, group1_high_pins_i, group1_low_pins_i};

  // ---------------------------------------------------------------------------
  // Pad cells
  // ---------------------------------------------------------------------------
  // Group one pins stay inputs here since their direction register is not in this bank
  generate
    for (genvar p = 0; p < N_PINS; p++) begin : g_pin
      pin_cfg_s cfg;
      assign cfg.dir = dir_vec[p];
      assign cfg.pol = pol_vec[p];
      assign cfg.od  = od_vec[p];
      assign cfg.dat = pin_out_q[p];

      gpio_pin_cell u_cell (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n),
        .pin_i     (pin_in_vec[p]),
        .cfg_i     (cfg),
        .pin_o     (pin_out_vec[p]),
        .pin_oe_o  (pin_oe_vec[p]),
        .in_val_o  (pin_in_val[p])
      );
    end
  endgenerate

  assign group1_low_pins_o     = pin_out_vec[2:0];
  assign group1_low_pins_oe_o  = pin_oe_vec[2:0];
  assign group1_high_pins_o    = pin_out_vec[4:3];
  assign group1_high_pins_oe_o = pin_oe_vec[4:3];
  assign group2_pins_o         = pin_out_vec[8:5];
  assign group2_pins_oe_o      = pin_oe_vec[8:5];
  assign group3_pins_o         = pin_out_vec[16:9];
  assign group3_pins_oe_o      = pin_oe_vec[16:9];

  // ---------------------------------------------------------------------------
  // Power management event output
  // ---------------------------------------------------------------------------
  // Non-inverted means the pin goes low while the event is active
  always_comb begin
    evt_level = g2_pol_q[EVT_POL_BIT] ? power_event_i : ~power_event_i;
    if (ctrl_q[CTRL_EVT_OD_BIT]) begin
      evt_d    = 1'b0;
      evt_oe_d = ~evt_level;
    end else begin
      evt_d    = evt_level;
      evt_oe_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      evt_q    <= 1'b1;
      evt_oe_q <= 1'b0;
    end else begin
      evt_q    <= evt_d;
      evt_oe_q <= evt_oe_d;
    end
  end

  assign power_event_out_n_o = evt_q;
  assign power_event_oe_o    = evt_oe_q;

endmodule

// ==== verilog/gpio_cfg_pkg.sv ====
// Package: register map, field masks, reset values and carrier types of the GPIO config bank
package gpio_cfg_pkg;

  // ---------------------------------------------------------------------------
  // Bus-side register byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL     = 12'h000;  // Config state and event driver type
  localparam logic [11:0] ADDR_INDEX    = 12'h004;  // Configuration index register
  localparam logic [11:0] ADDR_DATA     = 12'h008;  // Window onto the indexed register
  localparam logic [11:0] ADDR_PIN_IN   = 12'h00C;  // Input levels after polarity
  localparam logic [11:0] ADDR_PIN_OUT  = 12'h010;  // Output data before polarity

  // ---------------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------------
  localparam int CTRL_CFG_STATE_BIT = 0;            // One while in configuration state
  localparam int CTRL_EVT_OD_BIT    = 1;            // Event output driver: 1 = open drain
  localparam logic [7:0] CTRL_MASK  = 8'h03;

  // ---------------------------------------------------------------------------
  // Indexed configuration registers
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IDX_G1_POL   = 8'h32;
  localparam logic [7:0] IDX_G2_DIR   = 8'h33;
  localparam logic [7:0] IDX_G2_POL   = 8'h34;
  localparam logic [7:0] IDX_G3_DIR   = 8'h35;
  localparam logic [7:0] IDX_G1_OTYPE = 8'h39;

  // Writable bits; every other bit is reserved and reads as zero
  localparam logic [7:0] MASK_G1_POL   = 8'hCE;
  localparam logic [7:0] MASK_G2_DIR   = 8'h0F;
  localparam logic [7:0] MASK_G2_POL   = 8'h2F;
  localparam logic [7:0] MASK_G3_DIR   = 8'hFF;
  localparam logic [7:0] MASK_G1_OTYPE = 8'hCE;
  localparam int         EVT_POL_BIT   = 5;

  // Reset value of every configuration register
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] IDX_RESET = 8'h00;

  // ---------------------------------------------------------------------------
  // Flat pin vector layout: g1 low, g1 high, g2, g3
  // ---------------------------------------------------------------------------
  localparam int N_G1_LO = 3;
  localparam int N_G1_HI = 2;
  localparam int N_G2    = 4;
  localparam int N_G3    = 8;
  localparam int N_PINS  = N_G1_LO + N_G1_HI + N_G2 + N_G3;
  localparam logic [N_PINS-1:0] PIN_RESET = '0;

  // Per-pin configuration carried to each pad cell
  typedef struct packed {
    logic dir;   // 1 = output
    logic pol;   // 1 = inverted
    logic od;    // 1 = open drain
    logic dat;   // Internal output value
  } pin_cfg_s;

endpackage

// ==== verilog/reset_sync.sv ====
// Reset release synchroniser: asynchronous assert, two-flop synchronous release
`timescale 1ns/10ps
module reset_sync (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  output logic      rst_n_o
);

  logic meta_q;
  logic hold_q;

  // ---------------------------------------------------------------------------
  // Release chain
  // ---------------------------------------------------------------------------
  // Two stages so release never lands mid-setup on the downstream flops
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      hold_q <= meta_q;
    end
  end

  assign rst_n_o = hold_q;

endmodule

// ==== verilog/gpio_pin_cell.sv ====
// One GPIO pad cell: input synchroniser, polarity and driver control
`timescale 1ns/10ps
module gpio_pin_cell import gpio_cfg_pkg::*; (
  input  wire logic     ref_clk_i,
  input  wire logic     rst_n_i,
  input  wire logic     pin_i,
  input  wire pin_cfg_s cfg_i,
  output logic          pin_o,
  output logic          pin_oe_o,
  output logic          in_val_o
);

  logic sync1_q;
  logic sync2_q;
  logic pin_d;
  logic pin_q;
  logic oe_d;
  logic oe_q;
  logic level;

  // ---------------------------------------------------------------------------
  // Input path
  // ---------------------------------------------------------------------------
  // Pin is asynchronous; only the second stage is looked at
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
    end
  end

  assign in_val_o = sync2_q ^ cfg_i.pol;

  // ---------------------------------------------------------------------------
  // Output path
  // ---------------------------------------------------------------------------
  // Open drain pulls low only; a high level is left to the external pull-up
  always_comb begin
    level = cfg_i.dat ^ cfg_i.pol;
    if (cfg_i.od) begin
      pin_d = 1'b0;
      oe_d  = cfg_i.dir & ~level;
    end else begin
      pin_d = level;
      oe_d  = cfg_i.dir;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      pin_q <= pin_d;
      oe_q  <= oe_d;
    end
  end

  assign pin_o    = pin_q;
  assign pin_oe_o = oe_q;

endmodule

// ==== tb/gpio_ext_circuit.sv ====
// Partner model: outside circuit seen by the GPIO pads
`timescale 1ns/10ps
module gpio_ext_circuit (
  input  wire logic [16:0] pin_o_i,
  input  wire logic [16:0] pin_oe_i,
  input  wire logic [16:0] ext_i,
  output logic      [16:0] level_o
);
  // Driven pads show the device level; released pads show the outside source,
  // never a stale copy of the last driven value
  assign level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_i);
endmodule

// ==== tb/gpio_dir_polarity_config_chk.sv ====
// Checker: bus handshake, config gating and pin behaviour of the GPIO bank
`timescale 1ns/10ps
module gpio_dir_polarity_config_chk import gpio_cfg_pkg::*; (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [3:0]  group2_pins_oe_o,
  input wire logic [7:0]  group3_pins_oe_o,
  input wire logic        power_event_i,
  input wire logic        power_event_out_n_o
);
  // ---------------------------------------------------------------------------
  // Shadow of accepted writes, so expectations need no peek inside
  // ---------------------------------------------------------------------------
  logic       cfg_q, cfg_d, od_q, od_d, pol_q, pol_d, wr_ok;
  logic [7:0] idx_q, idx_d, g3d_q, g3d_d;
  logic [3:0] g2d_q, g2d_d;
  assign wr_ok = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
  // Refused writes leave the shadow alone, as they leave the device alone
  always_comb begin
    {cfg_d, od_d, pol_d, idx_d, g2d_d, g3d_d} = {cfg_q, od_q, pol_q, idx_q, g2d_q, g3d_q};
    if (wr_ok && paddr_i == ADDR_CTRL) {od_d, cfg_d} = pwdata_i[1:0];
    if (wr_ok && paddr_i == ADDR_INDEX) idx_d = pwdata_i[7:0];
    if (wr_ok && paddr_i == ADDR_DATA && idx_q == IDX_G2_DIR) g2d_d = pwdata_i[3:0];
    if (wr_ok && paddr_i == ADDR_DATA && idx_q == IDX_G3_DIR) g3d_d = pwdata_i[7:0];
    if (wr_ok && paddr_i == ADDR_DATA && idx_q == IDX_G2_POL) pol_d = pwdata_i[5];
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) {cfg_q, od_q, pol_q, idx_q, g2d_q, g3d_q} <= '0;
    else {cfg_q, od_q, pol_q, idx_q, g2d_q, g3d_q} <= {cfg_d, od_d, pol_d, idx_d, g2d_d, g3d_d};
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  rdy_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held past one cycle");
  rdy_timing_a: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
    else $error("ready not in second access cycle");
  rdy_phase_a: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access phase");
  idle_zero_a: assert property (!pready_o |-> prdata_o == '0 && !pslverr_o)
    else $error("read data or error outside completion");
  cfg_gate_a: assert property (pready_o && paddr_i == ADDR_DATA && !cfg_q |-> pslverr_o)
    else $error("window open outside config state");
  rsvd_dir_a: assert property (pready_o && !pwrite_i && paddr_i == ADDR_DATA && cfg_q
    && idx_q == IDX_G2_DIR |-> prdata_o == {28'h0, g2d_q}) else $error("direction readback");
  rsvd_pol_a: assert property (pready_o && !pwrite_i && paddr_i == ADDR_DATA && cfg_q
    && idx_q == IDX_G2_POL |-> prdata_o[31:4] == {26'h0, pol_q, 1'h0}) else $error("polarity");
  g2_dir_a: assert property (group2_pins_oe_o == $past(g2d_q))
    else $error("group two enable differs from direction");
  g3_dir_a: assert property (group3_pins_oe_o == $past(g3d_q))
    else $error("group three enable differs from direction");
  evt_pol_a: assert property (!$past(od_q) |->
    power_event_out_n_o == ($past(pol_q) ^ !$past(power_event_i))) else $error("event level");
endmodule

bind gpio_dir_polarity_config gpio_dir_polarity_config_chk i_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .group2_pins_oe_o(group2_pins_oe_o),
  .group3_pins_oe_o(group3_pins_oe_o), .power_event_i(power_event_i),
  .power_event_out_n_o(power_event_out_n_o));

// ==== tb/test_gpio_dir_polarity_config.sv ====
// Testbench: register access, gating, pin and power event checks of the GPIO bank
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module test_gpio_dir_polarity_config import gpio_cfg_pkg::*; ;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, evt, evt_n, evt_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [16:0] pin_o, pin_oe, ext, lvl;
  int          miscompares, compares;
  localparam logic [16:0] PD = 17'h1_3E40;  // Output data pattern

  gpio_dir_polarity_config i_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .group1_low_pins_i(lvl[2:0]), .group1_low_pins_o(pin_o[2:0]),
    .group1_low_pins_oe_o(pin_oe[2:0]), .group1_high_pins_i(lvl[4:3]),
    .group1_high_pins_o(pin_o[4:3]), .group1_high_pins_oe_o(pin_oe[4:3]),
    .group2_pins_i(lvl[8:5]), .group2_pins_o(pin_o[8:5]), .group2_pins_oe_o(pin_oe[8:5]),
    .group3_pins_i(lvl[16:9]), .group3_pins_o(pin_o[16:9]), .group3_pins_oe_o(pin_oe[16:9]),
    .power_event_i(evt), .power_event_out_n_o(evt_n), .power_event_oe_o(evt_oe));
  gpio_ext_circuit i_ext (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .ext_i(ext), .level_o(lvl));

  // ---------------------------------------------------------------------------
  // Bus and reporting tasks
  // ---------------------------------------------------------------------------
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One transfer; waits for ready under a bound, since a hung slave must not hang the run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      miscompares++;
      results();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'h1, a, d, r, e);
    `CHK("write error", ee, e)
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ex, input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'h0, a, 32'h0, r, e);
    `CHK("read data", ex, r)
    `CHK("read error", ee, e)
  endtask
  task automatic cw(input logic [7:0] i, input logic [7:0] d);
    wr(ADDR_INDEX, {24'h0, i}, 1'h0);
    wr(ADDR_DATA, {24'h0, d}, 1'h0);
  endtask
  task automatic cr(input logic [7:0] i, input logic [7:0] ex, input logic ee);
    wr(ADDR_INDEX, {24'h0, i}, 1'h0);
    rd(ADDR_DATA, {24'h0, ex}, ee);
  endtask
  // Lets pin updates land, then samples away from the driving edge
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    `CHK("pin enables", 17'h0, pin_oe)
    `CHK("pin drive", 17'h0, pin_o)
    `CHK("event pin", 1'h1, evt_n)
    $display("test reset done");
  endtask
  task automatic t_gate();
    rd(ADDR_DATA, 32'h0, 1'h1);
    wr(ADDR_INDEX, {24'h0, IDX_G2_POL}, 1'h0);
    wr(ADDR_DATA, 32'h2F, 1'h1);
    rd(12'h020, 32'h0, 1'h1);
    wr(ADDR_CTRL, 32'h1, 1'h0);
    cr(IDX_G2_POL, 8'h00, 1'h0);
    cr(8'h36, 8'h00, 1'h1);
    $display("test gate done");
  endtask
  task automatic t_regs();
    logic [7:0] ix [5] = '{IDX_G1_POL, IDX_G2_DIR, IDX_G2_POL, IDX_G3_DIR, IDX_G1_OTYPE};
    logic [7:0] mk [5] = '{8'hCE, 8'h0F, 8'h2F, 8'hFF, 8'hCE};
    foreach (ix[k]) begin
      cr(ix[k], 8'h00, 1'h0);
      cw(ix[k], 8'hFF);
      cr(ix[k], mk[k], 1'h0);
      cw(ix[k], 8'h00);
      cr(ix[k], 8'h00, 1'h0);
    end
    $display("test registers done");
  endtask
  task automatic t_pins();
    @(posedge clk);
    ext <= {8'h3C, 4'h0, 5'h05};
    cw(IDX_G1_POL, 8'hCE);
    cw(IDX_G2_DIR, 8'h0F);
    cw(IDX_G2_POL, 8'h05);
    cw(IDX_G3_DIR, 8'h81);
    wr(ADDR_PIN_OUT, {15'h0, PD}, 1'h0);
    pause(3);
    `CHK("group2 enable", 4'hF, pin_oe[8:5])
    `CHK("group2 level", PD[8:5] ^ 4'h5, pin_o[8:5])
    `CHK("group3 enable", 8'h81, pin_oe[16:9])
    `CHK("group3 level", PD[16:9] & 8'h81, pin_o[16:9] & 8'h81)
    // Group one stays input here, but its drive level still follows polarity
    `CHK("group1 drive", {5'h00, 5'h1F}, {pin_oe[4:0], pin_o[4:0]})
    rd(ADDR_PIN_OUT, {15'h0, PD}, 1'h0);
    rd(ADDR_PIN_IN, {15'h0, PD[16:9] & 8'h81 | 8'h3C & 8'h7E, PD[8:5], 5'h1A}, 1'h0);
    cw(IDX_G1_POL, 8'h00);
    rd(ADDR_PIN_IN, {15'h0, PD[16:9] & 8'h81 | 8'h3C & 8'h7E, PD[8:5], 5'h05}, 1'h0);
    $display("test pins done");
  endtask
  task automatic t_event();
    logic lv;
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      evt <= k[0];
      cw(IDX_G2_POL, {2'h0, k[1], 5'h05});
      if (k == 4) wr(ADDR_CTRL, 32'h3, 1'h0);
      pause(3);
      lv = k[1] ^ !k[0];
      if (k < 4) begin
        `CHK("event level", lv, evt_n)
        `CHK("event enable", 1'h1, evt_oe)
      end else begin
        `CHK("event open drain enable", !lv, evt_oe)
        `CHK("event open drain drive", 1'h0, evt_n)
      end
    end
    wr(ADDR_CTRL, 32'h0, 1'h0);
    rd(ADDR_DATA, 32'h0, 1'h1);
    $display("test event done");
  endtask
  // Reset in mid-run: registers left non-zero must come back cleared
  task automatic t_rerst();
    @(posedge clk);
    evt   <= 1'h0;
    rst_n <= 1'h0;
    pause(2);
    `CHK("outputs in reset", {1'h1, 1'h0, 17'h0}, {evt_n, evt_oe, pin_oe})
    @(posedge clk);
    rst_n <= 1'h1;
    pause(3);
    rd(ADDR_PIN_OUT, 32'h0, 1'h0);
    wr(ADDR_CTRL, 32'h1, 1'h0);
    cr(IDX_G2_DIR, 8'h00, 1'h0);
    cr(IDX_G2_POL, 8'h00, 1'h0);
    cr(IDX_G3_DIR, 8'h00, 1'h0);
    $display("test second reset done");
  endtask

  // ---------------------------------------------------------------------------
  // Clock, reset and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rst_n, psel, penable, pwrite, evt} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    ext = 17'h0;
    compares = 0;
    miscompares = 0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    t_reset();
    @(posedge clk);
    rst_n <= 1'h1;
    pause(3);
    t_gate();
    t_regs();
    t_pins();
    t_event();
    t_rerst();
    results();
  end
endmodule
